// ===== rtl/aswr_pkg.sv
// constants and types for the antenna switch register bank
package aswr_pkg;
  // ==========================================================
  // register map
  localparam logic [4:0] A_BANK_B  = 5'h00;
  localparam logic [4:0] A_BANK_A  = 5'h01;
  localparam logic [4:0] A_STATUS  = 5'h1a;
  localparam logic [4:0] A_GROUP_SLAVE_IDENTIFIER    = 5'h1b;
  localparam logic [4:0] A_PWRTRIG = 5'h1c;
  localparam logic [4:0] A_PART    = 5'h1d;
  localparam logic [4:0] A_MAKER_L = 5'h1e;
  localparam logic [4:0] A_MAKER_H = 5'h1f;
  // ==========================================================
  // field positions and codes
  localparam int SOFT_RST_BIT = 7;
  localparam int ERR_CMD_PAR  = 6;
  localparam int ERR_CMD_LEN  = 5;
  localparam int ERR_DAT_PAR  = 3;
  localparam int ERR_RD_UNUSED = 2;
  localparam int ERR_WR_UNUSED = 1;
  localparam int ERR_BID_GID  = 0;
  localparam logic [1:0] P_ACT  = 2'h0;
  localparam logic [1:0] P_SU   = 2'h1;
  localparam logic [1:0] P_LOW  = 2'h2;
  localparam logic [2:0] C_WR   = 3'h2;
  localparam logic [2:0] C_RD   = 3'h3;
  localparam logic [2:0] MASK_ALL = 3'h7;
  localparam logic [4:0] PC1 = 5'h01;
  localparam logic [4:0] PC2 = 5'h02;
  localparam logic [4:0] PC3 = 5'h04;
  localparam logic [4:0] PC4 = 5'h07;
  localparam logic [4:0] PC5 = 5'h0b;
  localparam logic [4:0] PC6 = 5'h10;
  // ==========================================================
  // reset values and identity (identity values are arbitrary)
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [6:0] ERR_RST  = 7'h00;
  localparam logic [3:0] GROUP_SLAVE_IDENTIFIER_RST = 4'h0;
  localparam logic [1:0] PWR_RST  = 2'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [3:0] MAKER_HIGH_AND_SLAVE_IDENTIFIER_RST = 4'ha;
  localparam logic [7:0] PART_ID  = 8'h5a;
  localparam logic [9:0] MAKER_ID = 10'h2c3;
  // ==========================================================
  // timing
  localparam int CLK_NS = 20;
  localparam int TSU_NS = 20000;
  localparam int TSU_CYC = TSU_NS / CLK_NS;
  localparam logic [9:0] SU_LOAD = 10'(TSU_CYC - 1);
  // ==========================================================
  // types
  typedef logic [7:0][7:0] aswr_image_t;
  typedef struct packed {
    logic       wr;
    logic [4:0] addr;
    logic [7:0] data;
    logic [6:0] err;
  } aswr_evt_t;
  typedef enum logic [7:0] {
    L_IDLE = 8'h01, L_HDR = 8'h02, L_CPAR = 8'h04, L_DAT = 8'h08,
    L_DPAR = 8'h10, L_PARK = 8'h20, L_RD = 8'h40, L_RPAR = 8'h80
  } aswr_lph_t;

  // slot of a register in the image: {valid, index}
  function automatic logic [3:0] aswr_slot(input logic [4:0] a);
    logic [3:0] s;
    s = 4'h0;
    if (a == A_BANK_B) s = 4'h8;
    else if (a == A_BANK_A) s = 4'h9;
    else if (a >= A_STATUS) s = {1'b1, 3'(a - A_STATUS + 5'h02)};
    return s;
  endfunction
endpackage

// ===== rtl/aswr_drv.sv
// read-back driver for the serial data pin, rising-edge side
`timescale 1ns/100ps
module aswr_drv import aswr_pkg::*; (
  // link clock and reset
  input  wire logic sclk,
  input  wire logic lrst_n,
  // next bit from the frame engine
  input  wire logic bit_i,
  input  wire logic en_i,
  // pin
  output logic      sdata_o,
  output logic      sdata_oe
);
  typedef struct packed {
    logic o;
    logic oe;
  } aswr_drv_st_t;
  aswr_drv_st_t q, d;

  always_comb begin
    d.o = bit_i;
    d.oe = en_i;
    if (!lrst_n) d = '0;
  end

  always_ff @(posedge sclk) q <= d;

  assign sdata_o  = q.o;
  assign sdata_oe = q.oe;
endmodule

// ===== rtl/aswr_link.sv
// serial frame engine on the link clock, sampling on the falling edge
`timescale 1ns/100ps
module aswr_link import aswr_pkg::*; (
  // link clock, reset level from the system side
  input  wire logic        sclk,
  input  wire logic        nrst,
  input  wire logic        sdata_i,
  // register image, frozen by the system side while busy
  input  wire aswr_image_t image,
  // event to the system side
  output aswr_evt_t        evt,
  output logic             evt_tog,
  output logic             busy,
  // to the pin driver
  output logic             lrst_n,
  output logic             bit_o,
  output logic             en_o
);
  typedef struct packed {
    logic       rm;
    logic       rs;
    aswr_lph_t  ph;
    logic [3:0] cnt;
    logic [11:0] sh;
    logic       par;
    logic       hit;
    logic       bo;
    logic       eo;
    aswr_evt_t  evt;
    logic       tog;
    logic       by;
  } aswr_lst_t;
  aswr_lst_t q, d;

  always_comb begin
    logic [3:0] sid;
    logic [3:0] slot;
    logic [7:0] word;
    logic [3:0] wslot;
    sid  = q.sh[11:8];
    // by the data parity the shifter holds data, so use the kept address
    wslot = aswr_slot(q.evt.addr);
    slot = aswr_slot(q.sh[4:0]);
    word = image[slot[2:0]];
    d = q;
    d.rm = nrst;
    d.rs = q.rm;
    unique case (q.ph)
      L_IDLE: if (sdata_i) begin
        d.ph = L_HDR;
        d.cnt = 4'h0;
        d.par = 1'b0;
      end
      L_HDR: begin
        d.sh = {q.sh[10:0], sdata_i};
        d.par = q.par ^ sdata_i;
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'hb) d.ph = L_CPAR;
      end
      L_CPAR: begin
        d.hit = sid == image[7][3:0] || sid == 4'h0 ||
                sid == image[3][3:0];
        d.evt = '0;
        d.evt.addr = q.sh[4:0];
        d.cnt = 4'h0;
        d.par = 1'b0;
        d.ph = L_IDLE;
        if (d.hit && !(q.par ^ sdata_i)) begin
          d.evt.err[ERR_CMD_PAR] = 1'b1;
          d.tog = ~q.tog;
        end else if (q.sh[7:5] == C_WR) begin
          d.ph = L_DAT;
        end else if (q.sh[7:5] == C_RD) begin
          d.ph = L_PARK;
          d.sh[7:0] = word;
          d.par = ~^word;
          if (d.hit && sid != image[7][3:0]) begin
            d.evt.err[ERR_BID_GID] = 1'b1;
            d.tog = ~q.tog;
            d.hit = 1'b0;
          end else if (d.hit && !slot[3]) begin
            d.evt.err[ERR_RD_UNUSED] = 1'b1;
            d.tog = ~q.tog;
            d.hit = 1'b0;
          end
        end else if (d.hit) begin
          d.evt.err[ERR_CMD_LEN] = 1'b1;
          d.tog = ~q.tog;
        end
      end
      L_DAT: begin
        d.sh = {q.sh[10:0], sdata_i};
        d.par = q.par ^ sdata_i;
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'h7) d.ph = L_DPAR;
      end
      L_DPAR: begin
        d.ph = L_IDLE;
        d.evt.data = q.sh[7:0];
        // the system side reads evt after the toggle crosses; the
        // master's spacing between writes keeps it stable
        if (q.hit) begin
          d.tog = ~q.tog;
          if (!(q.par ^ sdata_i)) d.evt.err[ERR_DAT_PAR] = 1'b1;
          else if (!wslot[3] || q.evt.addr == A_PART ||
                   q.evt.addr == A_MAKER_L)
            d.evt.err[ERR_WR_UNUSED] = 1'b1;
          else d.evt.wr = 1'b1;
        end
      end
      L_PARK: begin
        d.eo = q.hit;
        d.bo = q.sh[7];
        d.sh = {q.sh[10:0], 1'b0};
        d.ph = L_RD;
      end
      L_RD: begin
        d.cnt = q.cnt + 4'h1;
        d.bo = q.sh[7];
        d.sh = {q.sh[10:0], 1'b0};
        if (q.cnt == 4'h7) begin
          d.bo = q.par;
          d.ph = L_RPAR;
        end
      end
      L_RPAR: begin
        d.eo = 1'b0;
        d.ph = L_IDLE;
      end
      default: d.ph = L_IDLE;
    endcase
    d.by = d.ph != L_IDLE;
    if (!q.rs) begin
      d = '0;
      d.rm = nrst;
      d.rs = q.rm;
      d.ph = L_IDLE;
    end
  end

  always_ff @(negedge sclk) q <= d;

  assign evt     = q.evt;
  assign evt_tog = q.tog;
  assign busy    = q.by;
  assign lrst_n  = q.rs;
  assign bit_o   = q.bo;
  assign en_o    = q.eo;
endmodule

// ===== rtl/aswr_regs.sv
// antenna switch register bank with serial link slave
`timescale 1ns/100ps
module aswr_regs import aswr_pkg::*; (
  // system clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // serial link
  input  wire logic       sclk,
  input  wire logic       sdata_i,
  output logic            sdata_o,
  output logic            sdata_oe,
  // switch control
  output logic [5:0]      first_bank_path,
  output logic [5:0]      second_bank_path,
  output logic [1:0]      power_state
);
  typedef struct packed {
    logic        tm;
    logic        ts;
    logic        seen;
    logic        bm;
    logic        bs;
    logic [7:0]  bank_a;
    logic [7:0]  bank_b;
    logic [7:0]  act_a;
    logic [7:0]  act_b;
    logic [6:0]  err;
    logic [3:0]  group_slave_identifier;
    logic [1:0]  pwr;
    logic [2:0]  mask;
    logic [3:0]  maker_high_and_slave_identifier;
    logic [9:0]  su;
    aswr_image_t img;
    logic [5:0]  pa;
    logic [5:0]  pb;
  } aswr_st_t;
  aswr_st_t q, d;

  // ==========================================================
  // link side
  aswr_evt_t evt;
  logic      evt_tog;
  logic      busy;
  logic      lrst_n;
  logic      lbit;
  logic      len;

  aswr_link u_link (
    .sclk    (sclk),
    .nrst    (nrst),
    .sdata_i (sdata_i),
    .image   (q.img),
    .evt     (evt),
    .evt_tog (evt_tog),
    .busy    (busy),
    .lrst_n  (lrst_n),
    .bit_o   (lbit),
    .en_o    (len)
  );

  aswr_drv u_drv (
    .sclk     (sclk),
    .lrst_n   (lrst_n),
    .bit_i    (lbit),
    .en_i     (len),
    .sdata_o  (sdata_o),
    .sdata_oe (sdata_oe)
  );

  // ==========================================================
  // decoding
  function automatic logic [5:0] path_dec(input logic [7:0] v);
    logic [5:0] p;
    unique case (v[4:0])
      PC1:     p = 6'h01;
      PC2:     p = 6'h02;
      PC3:     p = 6'h04;
      PC4:     p = 6'h08;
      PC5:     p = 6'h10;
      PC6:     p = 6'h20;
      default: p = 6'h00;
    endcase
    return p;
  endfunction

  function automatic aswr_st_t regs_def(input aswr_st_t s);
    aswr_st_t r;
    r = s;
    r.bank_a = BANK_RST;
    r.bank_b = BANK_RST;
    r.act_a  = BANK_RST;
    r.act_b  = BANK_RST;
    r.err    = ERR_RST;
    r.group_slave_identifier   = GROUP_SLAVE_IDENTIFIER_RST;
    r.pwr    = PWR_RST;
    r.mask   = MASK_RST;
    r.maker_high_and_slave_identifier   = MAKER_HIGH_AND_SLAVE_IDENTIFIER_RST;
    return r;
  endfunction

  // ==========================================================
  // register behaviour
  logic evt_new;
  assign evt_new = q.ts ^ q.seen;

  always_comb begin
    d = q;
    d.tm = evt_tog;
    d.ts = q.tm;
    d.bm = busy;
    d.bs = q.bm;
    if (q.su != 10'h000) d.su = q.su - 10'h001;
    if (evt_new) begin
      d.seen = q.ts;
      if (evt.wr) begin
        unique case (evt.addr)
          A_BANK_A: begin
            d.bank_a = evt.data;
            if (q.mask == MASK_ALL) d.act_a = evt.data;
          end
          A_BANK_B: begin
            d.bank_b = evt.data;
            if (q.mask == MASK_ALL) d.act_b = evt.data;
          end
          A_STATUS: if (evt.data[SOFT_RST_BIT]) d = regs_def(d);
          A_GROUP_SLAVE_IDENTIFIER:   d.group_slave_identifier = evt.data[3:0];
          A_PWRTRIG: begin
            d.mask = evt.data[5:3];
            // a load only fires for a trigger that is enabled
            for (int i = 0; i < 3; i++) begin
              if (evt.data[i] && !evt.data[3+i]) begin
                d.act_a = q.bank_a;
                d.act_b = q.bank_b;
              end
            end
            unique case (evt.data[7:6])
              P_ACT: d.pwr = P_ACT;
              P_SU: begin
                d = regs_def(d);
                d.pwr = P_LOW;
                d.su = SU_LOAD;
              end
              P_LOW: d.pwr = P_LOW;
              default: d.pwr = q.pwr;
            endcase
          end
          A_MAKER_H: d.maker_high_and_slave_identifier = evt.data[3:0];
          default: d.pwr = d.pwr;
        endcase
      end
      // error flags set after any clear, so a new error is never lost
      d.err = d.err | evt.err;
    end
    // paths stay isolated until the start-up time has run out
    if (d.pwr == P_ACT && q.su == 10'h000) begin
      d.pa = path_dec(d.act_a);
      d.pb = path_dec(d.act_b);
    end else begin
      d.pa = 6'h00;
      d.pb = 6'h00;
    end
    // the image only moves while no frame runs, so the link sees it still
    if (!q.bs) begin
      d.img[0] = q.bank_b;
      d.img[1] = q.bank_a;
      d.img[2] = {1'b0, q.err};
      d.img[3] = {4'h0, q.group_slave_identifier};
      d.img[4] = {q.pwr, q.mask, 3'h0};
      d.img[5] = PART_ID;
      d.img[6] = MAKER_ID[7:0];
      d.img[7] = {2'h0, MAKER_ID[9:8], q.maker_high_and_slave_identifier};
    end
    if (!nrst) begin
      d = regs_def('0);
      d.seen = q.ts;
      d.su = SU_LOAD;
    end
  end

  always_ff @(posedge clk) q <= d;

  assign first_bank_path  = q.pa;
  assign second_bank_path = q.pb;
  assign power_state      = q.pwr;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic wr_a;
  logic wr_pt;
  logic wr_st;
  assign wr_a  = evt_new && evt.wr && evt.addr == A_BANK_A;
  assign wr_pt = evt_new && evt.wr && evt.addr == A_PWRTRIG;
  assign wr_st = evt_new && evt.wr && evt.addr == A_STATUS;

  pwr_legal_a: assert property (q.pwr != P_SU && q.pwr != 2'h3)
    else $error("power state shows an illegal code");
  startup_low_a: assert property (
    wr_pt && evt.data[7:6] == P_SU |=> q.pwr == P_LOW &&
    q.act_a == BANK_RST && q.mask == MASK_RST)
    else $error("start-up did not reset into low power");
  bad_pwr_keep_a: assert property (
    wr_pt && evt.data[7:6] == 2'h3 |=> $stable(q.pwr))
    else $error("discarded power code changed the state");
  startup_time_a: assert property (
    $rose(q.su == SU_LOAD) |-> ##[1:1000] q.su == 10'h000)
    else $error("start-up time exceeded");
  soft_reset_a: assert property (
    wr_st && evt.data[SOFT_RST_BIT] && evt.err == 7'h00
    |=> q.err == ERR_RST && q.bank_a == BANK_RST && q.pwr == P_ACT)
    else $error("soft reset left state behind");
  path_now_a: assert property (
    wr_a && q.mask == MASK_ALL |=> q.act_a == $past(evt.data))
    else $error("untriggered write not applied");
  path_held_a: assert property (
    wr_a && q.mask != MASK_ALL |=> $stable(q.act_a))
    else $error("triggered write applied before load");
  path_onehot_a: assert property ($onehot0(q.pa) &&
    (q.pwr == P_ACT || q.pa == 6'h00))
    else $error("path select not one-hot or not isolated");
  mask_load_a: assert property (wr_pt && evt.data[7:6] != P_SU |=>
    q.mask == $past(evt.data[5:3]) && q.img[4][2:0] == 3'h0)
    else $error("trigger mask not taken");
  err_cause_a: assert property (!evt_new |=>
    (q.err & ~$past(q.err)) == 7'h00)
    else $error("status flag set without an event");

  startup_c: cover property (wr_pt && evt.data[7:6] == P_SU);
  trig_load_c: cover property (wr_pt && evt.data[2:0] != 3'h0 ##1
    q.act_a != $past(q.act_a));
  err_seen_c: cover property (evt_new && evt.err != 7'h00);
  path_six_c: cover property (q.pa == 6'h20);
endmodule

// ===== testbench/aswr_master.sv
// serial bus master model that drives the link clock and data line
`timescale 1ns/100ps
module aswr_master import aswr_pkg::*; (
  // link pins
  output logic      sclk,
  output wire logic sdata_i,
  // device side of the data pin
  input  wire logic sdata_o,
  input  wire logic sdata_oe
);
  logic den;
  logic dv;
  logic last;
  logic smp;
  // ==========================================================
  // wire level
  // a released line shows the inverse of its last level, so a stale
  // value can never pass for read data
  assign sdata_i = sdata_oe ? sdata_o : (den ? dv : ~last);
  initial begin
    sclk = 1'b0;
    den = 1'b1;
    dv = 1'b0;
    last = 1'b0;
    smp = 1'b0;
  end
  // ==========================================================
  // link cycles
  // change on the rise; sclk stands low between frames
  task automatic cyc(input logic b, input logic en);
    sclk = 1'b1;
    den = en;
    dv = b;
    #7.5;
    sclk = 1'b0;
    smp = sdata_i;
    last = sdata_i;
    #7.5;
  endtask
  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b1);
  endtask
  // one frame; bad flips the data parity of a write
  task automatic xfer(input logic [3:0] id, input logic [2:0] cmd,
                      input logic [4:0] a, input logic [7:0] wd,
                      input logic bad, output logic [7:0] rd);
    logic [13:0] h;
    h = {1'b1, id, cmd, a, ~^{id, cmd, a}};
    rd = 8'h00;
    for (int i = 13; i >= 0; i--) begin
      cyc(h[i], 1'b1);
    end
    if (cmd == C_RD) begin
      cyc(1'b0, 1'b0);
      for (int i = 7; i >= 0; i--) begin
        cyc(1'b0, 1'b0);
        rd[i] = smp;
      end
      cyc(1'b0, 1'b0);
    end else begin
      for (int i = 7; i >= 0; i--) begin
        cyc(wd[i], 1'b1);
      end
      cyc((~^wd) ^ bad, 1'b1);
    end
    idle(2);
  endtask
endmodule

// ===== testbench/tb_aswr_regs.sv
// self-checking bench for the antenna switch register bank
`timescale 1ns/100ps
module tb_aswr_regs import aswr_pkg::*;;
  logic       clk;
  logic       nrst;
  wire        sclk;
  wire        sdata_i;
  logic       sdata_o;
  logic       sdata_oe;
  logic [5:0] pa;
  logic [5:0] pb;
  logic [1:0] pwr;
  logic [7:0] rd;
  int         num_errors;
  int         checked;
  aswr_regs uut (.clk(clk), .nrst(nrst), .sclk(sclk), .sdata_i(sdata_i),
                 .sdata_o(sdata_o), .sdata_oe(sdata_oe),
                 .first_bank_path(pa), .second_bank_path(pb),
                 .power_state(pwr));
  aswr_master m (.sclk(sclk), .sdata_i(sdata_i), .sdata_o(sdata_o),
                 .sdata_oe(sdata_oe));
  initial clk = 1'b0;
  always #10 clk = ~clk;
  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // writes are spaced well beyond the device's minimum gap
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] x;
    m.xfer(MAKER_HIGH_AND_SLAVE_IDENTIFIER_RST, C_WR, a, d, 1'b0, x);
    repeat (10) @(negedge clk);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] exp,
                      input string what);
    logic [7:0] d;
    m.xfer(MAKER_HIGH_AND_SLAVE_IDENTIFIER_RST, C_RD, a, 8'h00, 1'b0, d);
    chk(d, exp, what);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    m.idle(4);
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    m.idle(3);
    repeat (1000) @(negedge clk);
    chk({2'b00, pa}, 8'h00, "bank a path at reset");
    chk({6'h00, pwr}, 8'h00, "power at reset");
    rchk(A_STATUS, 8'h00, "status reset");
    rchk(A_PWRTRIG, 8'h00, "power/trigger reset");
    rchk(A_GROUP_SLAVE_IDENTIFIER, {4'h0, GROUP_SLAVE_IDENTIFIER_RST}, "group id reset");
    rchk(A_PART, PART_ID, "part id");
    rchk(A_MAKER_L, MAKER_ID[7:0], "maker low");
    rchk(A_MAKER_H, {2'b00, MAKER_ID[9:8], MAKER_HIGH_AND_SLAVE_IDENTIFIER_RST}, "maker high");
  endtask
  task automatic t_paths();
    logic [4:0] code [8];
    logic [5:0] hot [8];
    code = '{PC1, PC2, PC3, PC4, PC5, PC6, 5'h00, 5'h03};
    hot = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h00, 6'h00};
    wr(A_PWRTRIG, 8'h38);
    for (int i = 0; i < 8; i++) begin
      wr(A_BANK_A, {3'h7, code[i]});
      wr(A_BANK_B, {3'(i), code[i]});
      chk(8'(pa), 8'(hot[i]), "bank a path");
      chk(8'(pb), 8'(hot[i]), "bank b path");
      rchk(A_BANK_A, {3'h7, code[i]}, "bank a readback");
      rchk(A_BANK_B, {3'(i), code[i]}, "bank b readback");
    end
  endtask
  task automatic t_trig();
    wr(A_BANK_A, {3'h0, PC1});
    chk(8'(pa), 8'h01, "path with triggers off");
    wr(A_PWRTRIG, 8'h30);
    wr(A_BANK_A, {3'h0, PC3});
    chk(8'(pa), 8'h01, "path held, trigger armed");
    wr(A_PWRTRIG, 8'h32);
    chk(8'(pa), 8'h01, "load of masked trigger");
    wr(A_PWRTRIG, 8'h31);
    chk(8'(pa), 8'h04, "path after load");
    rchk(A_PWRTRIG, 8'h30, "load bits read zero");
  endtask
  task automatic t_err();
    wr(A_PART, 8'h00);
    m.xfer(MAKER_HIGH_AND_SLAVE_IDENTIFIER_RST, C_WR, A_BANK_A, 8'h10, 1'b1, rd);
    repeat (10) @(negedge clk);
    m.xfer(MAKER_HIGH_AND_SLAVE_IDENTIFIER_RST, C_RD, 5'h05, 8'h00, 1'b0, rd);
    m.xfer(4'h0, C_RD, A_STATUS, 8'h00, 1'b0, rd);
    rchk(A_STATUS, 8'h0f, "error flags");
    rchk(A_BANK_A, {3'h0, PC3}, "kept after bad parity");
    wr(A_STATUS, 8'h80);
    rchk(A_STATUS, 8'h00, "flags after soft reset");
    rchk(A_BANK_A, BANK_RST, "bank after soft reset");
  endtask
  task automatic t_power();
    wr(A_PWRTRIG, 8'hb8);
    chk({6'h00, pwr}, {6'h00, P_LOW}, "low power");
    chk(8'(pa), 8'h00, "isolated in low power");
    rchk(A_PWRTRIG, 8'hb8, "low power readback");
    wr(A_PWRTRIG, 8'hf8);
    chk({6'h00, pwr}, {6'h00, P_LOW}, "code 11 discarded");
    m.xfer(MAKER_HIGH_AND_SLAVE_IDENTIFIER_RST, C_RD, A_PWRTRIG, 8'h00, 1'b0, rd);
    chk({6'h00, rd[7:6]}, {6'h00, P_LOW}, "11 never read");
    wr(A_PWRTRIG, 8'h38);
    chk({6'h00, pwr}, {6'h00, P_ACT}, "active");
    rchk(A_PWRTRIG, 8'h38, "active readback");
    wr(A_BANK_A, {3'h0, PC2});
    wr(A_PWRTRIG, 8'h78);
    chk({6'h00, pwr}, {6'h00, P_LOW}, "start-up to low");
    rchk(A_BANK_A, BANK_RST, "defaults after start-up");
    rchk(A_PWRTRIG, 8'h80, "start-up readback");
  endtask
  // ==========================================================
  // main sequence and hang guard
  initial begin
    nrst = 1'b0;
    num_errors = 0;
    checked = 0;
    t_reset();
    t_paths();
    t_trig();
    t_err();
    t_power();
    conclude();
  end
  initial begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule
